// File: logic/cdv_pkg.sv
`default_nettype none
package cdv_pkg;
	// three-flop pin synchroniser depth
	localparam int SYNC_DEPTH = 3;
	// divider chain width: bit0 is /2, bit1 is /4, bit2 is /8
	localparam int DIV_WIDTH = 3;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [2:0] DIV_STEP = 3'h1;
	// bit positions inside the divider chain
	localparam int HALF_BIT = 0;
	localparam int QUARTER_BIT = 1;
	localparam int EIGHTH_BIT = 2;
	// an open gate or clear pin reads as low
	localparam logic [2:0] SYNC_RESET = 3'h0;
	localparam logic GATE_RESET = 1'b0;

	typedef struct packed {
		logic eighth;
		logic quarter;
		logic half;
	} cdv_rates_s;
endpackage
`default_nettype wire

// File: logic/cdv_divider.sv
// Behaviour
// RULE1 - Three outputs give the source clock divided by two, four and eight.
// RULE2 - All three stages advance on one shared event so common edges align.
// RULE3 - A gate change only takes effect while the source clock is low.
// RULE4 - The active-low gate is captured on the falling source clock edge.
// RULE5 - Stages advance on rising source edges while gated on and not clear.
// RULE6 - A high clear forces all outputs low regardless of clock and gate.
// RULE7 - A gate or clear pin left open reads low, so division runs freely.
// RULE8 - After clear, all outputs rise together on the next rising edge.
`timescale 1ns/100ps
`default_nettype none
module cdv_divider
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic src_clk_in,
	input wire logic gate_n_in,
	input wire logic sync_clear_in,
	output logic half_rate_out,
	output logic quarter_rate_out,
	output logic eighth_rate_out
);
	logic [2:0] sync_clk;
	logic [2:0] sync_gate;
	logic [2:0] sync_clr;
	// filtered levels: a pin counts only once two flops agree, trading
	// four cycles of latency for immunity to a metastable first stage
	logic f_clk;
	logic f_clk_prev;
	logic f_gate;
	logic f_clr;
	logic gate_q;
	logic [cdv_pkg::DIV_WIDTH-1:0] count;
	cdv_pkg::cdv_rates_s rates;

	wire src_rise = f_clk & ~f_clk_prev;
	wire src_fall = ~f_clk & f_clk_prev;
	// a change is accepted only once stages two and three agree
	wire next_f_clk = (sync_clk[1] == sync_clk[2]) ? sync_clk[2] : f_clk;
	wire next_f_gate = (sync_gate[1] == sync_gate[2]) ? sync_gate[2] : f_gate;
	wire next_f_clr = (sync_clr[1] == sync_clr[2]) ? sync_clr[2] : f_clr;
	wire advance = src_rise & ~gate_q & ~f_clr;
	// down counting makes every stage rise together leaving reset
	wire [cdv_pkg::DIV_WIDTH-1:0] next_count = count - cdv_pkg::DIV_STEP;

	// RULE7 open pins low
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sync_clk <= cdv_pkg::SYNC_RESET;
			sync_gate <= cdv_pkg::SYNC_RESET;
			sync_clr <= cdv_pkg::SYNC_RESET;
			f_clk <= 1'b0;
			f_clk_prev <= 1'b0;
			f_gate <= cdv_pkg::GATE_RESET;
			f_clr <= 1'b0;
		end
		else if (ce_in)
		begin
			sync_clk <= {sync_clk[1:0], src_clk_in};
			sync_gate <= {sync_gate[1:0], gate_n_in};
			sync_clr <= {sync_clr[1:0], sync_clear_in};
			f_clk <= next_f_clk;
			f_clk_prev <= f_clk;
			f_gate <= next_f_gate;
			f_clr <= next_f_clr;
		end
	end

	// RULE4 falling edge capture
	// RULE3 only when clock low: capture on the fall avoids runt stage pulses
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			gate_q <= cdv_pkg::GATE_RESET;
		else if (ce_in && src_fall)
			gate_q <= f_gate;
	end

	// RULE6 clear wins always
	// RULE5 advance or hold
	// RULE2 one shared event
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			count <= cdv_pkg::DIV_RESET;
		else if (ce_in && f_clr)
			count <= cdv_pkg::DIV_RESET;
		else if (ce_in && advance)
			count <= next_count;
	end

	// RULE1 divided outputs
	assign rates.half = count[cdv_pkg::HALF_BIT];
	assign rates.quarter = count[cdv_pkg::QUARTER_BIT];
	assign rates.eighth = count[cdv_pkg::EIGHTH_BIT];
	assign half_rate_out = rates.half;
	assign quarter_rate_out = rates.quarter;
	assign eighth_rate_out = rates.eighth;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// RULE6 clear check
	clear_forces_low_a: assert property ( // RULE6
		ce_in && f_clr |=> count == cdv_pkg::DIV_RESET)
		else $error("clear did not force outputs low");

	// RULE5 gated hold
	hold_when_gated_a: assert property ( // RULE5
		ce_in && gate_q && !f_clr |=> $stable(count))
		else $error("divider moved while gated off");

	// RULE5 advance step
	advance_on_rise_a: assert property ( // RULE5
		ce_in && advance |=> count == $past(count) - cdv_pkg::DIV_STEP)
		else $error("divider did not advance on rising edge");

	// RULE2 shared event
	idle_between_edges_a: assert property ( // RULE2
		(!ce_in || (!src_rise && !f_clr)) |=> $stable(count))
		else $error("divider moved without a rising edge");

	// RULE4 falling capture
	gate_on_fall_a: assert property ( // RULE4
		ce_in && src_fall |=> gate_q == $past(f_gate))
		else $error("gate not captured on falling edge");

	// RULE3 low phase only
	gate_only_low_a: assert property ( // RULE3
		!(ce_in && src_fall) |=> $stable(gate_q))
		else $error("gate changed outside the low phase");

	// RULE1 half rate
	half_toggles_a: assert property ( // RULE1
		ce_in && advance |=> half_rate_out != $past(half_rate_out))
		else $error("half rate output did not toggle");

	// RULE1 quarter rate
	quarter_ratio_a: assert property ( // RULE1
		ce_in && advance |=> quarter_rate_out ==
			($past(quarter_rate_out) ^ !$past(half_rate_out)))
		else $error("quarter rate output out of step");

	// RULE1 eighth rate
	eighth_ratio_a: assert property ( // RULE1
		ce_in && advance |=> eighth_rate_out == ($past(eighth_rate_out)
			^ (!$past(half_rate_out) && !$past(quarter_rate_out))))
		else $error("eighth rate output out of step");

	// RULE8 common first rise
	first_edge_a: assert property ( // RULE8
		ce_in && advance && count == cdv_pkg::DIV_RESET |=>
			half_rate_out && quarter_rate_out && eighth_rate_out)
		else $error("outputs did not rise together after clear");

	// RULE5 source filter take
	clk_filter_take_a: assert property ( // RULE5
		ce_in && sync_clk[1] == sync_clk[2] |=>
			f_clk == $past(sync_clk[2]))
		else $error("source filter missed an agreed level");

	// RULE5 source filter hold
	clk_filter_hold_a: assert property ( // RULE5
		ce_in && sync_clk[1] != sync_clk[2] |=> $stable(f_clk))
		else $error("source filter took an unsettled level");

	// RULE4 gate filter take
	gate_filter_take_a: assert property ( // RULE4
		ce_in && sync_gate[1] == sync_gate[2] |=>
			f_gate == $past(sync_gate[2]))
		else $error("gate filter missed an agreed level");

	// RULE4 gate filter hold
	gate_filter_hold_a: assert property ( // RULE4
		ce_in && sync_gate[1] != sync_gate[2] |=> $stable(f_gate))
		else $error("gate filter took an unsettled level");

	// RULE6 clear filter take
	clr_filter_take_a: assert property ( // RULE6
		ce_in && sync_clr[1] == sync_clr[2] |=>
			f_clr == $past(sync_clr[2]))
		else $error("clear filter missed an agreed level");

	// RULE6 clear filter hold
	clr_filter_hold_a: assert property ( // RULE6
		ce_in && sync_clr[1] != sync_clr[2] |=> $stable(f_clr))
		else $error("clear filter took an unsettled level");

	// RULE5 edge history
	prev_tracks_a: assert property ( // RULE5
		ce_in |=> f_clk_prev == $past(f_clk))
		else $error("edge detector history out of step");

	// RULE2 single step
	count_step_a: assert property ( // RULE2
		ce_in && !f_clr |=> count == $past(count) ||
			count == $past(count) - cdv_pkg::DIV_STEP)
		else $error("divider jumped by more than one step");

	// RULE3 frozen gate
	freeze_gate_a: assert property ( // RULE3
		!ce_in |=> $stable(gate_q))
		else $error("gate register moved while frozen");

	// RULE5 frozen chains
	freeze_sync_a: assert property ( // RULE5
		!ce_in |=> $stable(sync_clk) && $stable(sync_gate) &&
			$stable(sync_clr))
		else $error("pin synchroniser moved while frozen");

	// RULE5 frozen filters
	freeze_filter_a: assert property ( // RULE5
		!ce_in |=> $stable(f_clk) && $stable(f_gate) && $stable(f_clr))
		else $error("pin filter moved while frozen");

	// main scenarios
	clear_seen_c: cover property (ce_in && f_clr ##1 !f_clr);
	freeze_c: cover property (!ce_in ##1 ce_in);
	full_cycle_c: cover property (ce_in && advance && count == 3'h1);
	gated_hold_c: cover property (ce_in && gate_q && src_rise);
	regate_c: cover property (gate_q ##1 !gate_q);
endmodule
`default_nettype wire

// File: tb/cdv_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module cdv_src_model
(
	input wire logic clk_in,
	output logic src_out
);
	initial src_out = 1'b0;
	// one source period, then stand low
	task automatic pulse();
		@(posedge clk_in) src_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		src_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// File: tb/cdv_divider_tb.sv
`timescale 1ns/100ps
`default_nettype none
module clock_divider_by_2_4_8_tb_top;
	logic clk_in = 1'b0, rst_in = 1'b1, gate_n = 1'b0, clr = 1'b0, src;
	logic ce = 1'b1;
	int err_count = 0, check_count = 0, cycles = 0;
	cdv_pkg::cdv_rates_s q;
	initial forever #12.5 clk_in = ~clk_in;
	cdv_src_model u_cdv_src_model (.clk_in(clk_in), .src_out(src));
	cdv_divider u_cdv_divider (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.src_clk_in(src), .gate_n_in(gate_n), .sync_clear_in(clr),
		.half_rate_out(q.half), .quarter_rate_out(q.quarter),
		.eighth_rate_out(q.eighth));
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %b want %b", $time, seen, exp);
		end
	endtask
	task automatic end_of_test(input int extra);
		err_count += extra;
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// gate and clear left low: free division, count runs down
	task automatic t_count();
		for (int n = 1; n <= 9; n++)
		begin
			u_cdv_src_model.pulse();
			check(q, 3'(-n));
		end
	endtask
	// gate lands at a source fall, so the first rise still counts
	task automatic t_gate();
		gate_n <= 1'b1;
		u_cdv_src_model.pulse();
		u_cdv_src_model.pulse();
		check(q, 3'h6);
		gate_n <= 1'b0;
		u_cdv_src_model.pulse();
		u_cdv_src_model.pulse();
		check(q, 3'h5);
	endtask
	// clear wins even while the source toggles
	task automatic t_clear();
		clr <= 1'b1;
		u_cdv_src_model.pulse();
		check(q, 3'h0);
		clr <= 1'b0;
		repeat (4) @(posedge clk_in);
		u_cdv_src_model.pulse();
		check(q, 3'h7);
	endtask
	// enable low freezes everything, a later rise still counts
	task automatic t_freeze();
		ce <= 1'b0;
		u_cdv_src_model.pulse();
		check(q, 3'h7);
		ce <= 1'b1;
		u_cdv_src_model.pulse();
		check(q, 3'h6);
	endtask
	initial
	begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		t_count();
		t_gate();
		t_clear();
		t_freeze();
		end_of_test(0);
	end
	always @(posedge clk_in)
		if (++cycles > 1000) end_of_test(1);
endmodule
`default_nettype wire
